// *** pbem_cfg.svh ***
// Offsets, field positions, reset values and counts of the lane self-test block.
`ifndef PBEM_CFG_SVH
`define PBEM_CFG_SVH
`define PBEM_WORD_W        32
`define PBEM_OFF_CTRL      12'h000
`define PBEM_OFF_STATUS    12'h004
`define PBEM_OFF_ERR_CNT   12'h008
`define PBEM_OFF_BIT_CNT   12'h00c
`define PBEM_OFF_RATE      12'h010
`define PBEM_OFF_DWELL     12'h014
`define PBEM_OFF_PHASE     12'h018
`define PBEM_OFF_BOUNDS    12'h01c
`define PBEM_OFF_LEVEL     12'h020
`define PBEM_OFF_EYE_BASE  12'h080
`define PBEM_EYE_MASK      12'hf80
`define PBEM_CTRL_RUN      0
`define PBEM_CTRL_LOOP     1
`define PBEM_CTRL_PAT_LO   2
`define PBEM_CTRL_PAT_HI   4
`define PBEM_CTRL_EYE_GO   8
`define PBEM_CTRL_CLR      9
`define PBEM_RATE_RST      16'h0000
`define PBEM_DWELL_RST     16'h0100
`define PBEM_BOUNDS_RST    16'h7f80
`define PBEM_EYE_MIN_MBPS  16'h0c35
`define PBEM_EYE_STEPS     32
`define PBEM_EYE_LAST      5'h1f
`define PBEM_SETTLE_CYC    4'h4
`define PBEM_PRBS_SEED     32'hffffffff
`define PBEM_TAP7_N        7
`define PBEM_TAP7_K        6
`define PBEM_TAP9_N        9
`define PBEM_TAP9_K        5
`define PBEM_TAP15_N       15
`define PBEM_TAP15_K       14
`define PBEM_TAP23_N       23
`define PBEM_TAP23_K       18
`define PBEM_TAP31_N       31
`define PBEM_TAP31_K       28
`endif

// *** pbem_lane_model.sv ***
// Behavioural lane model: loopback path, far-end traffic and eye samplers.
`timescale 1ns/1ps
module pbem_lane_model (
  // Clock.
  input  wire logic        mclk_i,
  // Block side.
  input  wire logic [31:0] tx_data_i,
  input  wire logic        loop_i,
  input  wire logic [4:0]  eye_phase_i,
  // Bench control.
  input  wire logic [31:0] flip_i,
  // Toward the block.
  output logic [31:0]      rx_data_o,
  output logic [31:0]      eye_center_o,
  output logic [31:0]      eye_offset_o
);
  // Far-end traffic changes every cycle, so a stale word never looks live.
  logic [31:0] ext_r = 32'h00000001;
  // Word slips are never issued, so alignment holds for the whole test.
  always_ff @(posedge mclk_i) begin
    ext_r     <= ext_r * 32'h0019660d + 32'h3c6ef35f;
    rx_data_o <= (loop_i ? tx_data_i : ext_r) ^ flip_i;
  end
  // The offset sampler misses one more bit for each phase step away from the centre.
  assign eye_center_o = ext_r;
  assign eye_offset_o = ext_r ^ ((32'h00000001 << eye_phase_i) - 32'h00000001);
endmodule : pbem_lane_model

// *** pbem_pkg.sv ***
// Types and helper functions of the lane self-test block.
package pbem_pkg;
  `include "pbem_cfg.svh"

  typedef enum logic [2:0] {
    PBEM_PRBS7  = 3'h0,
    PBEM_PRBS9  = 3'h1,
    PBEM_PRBS15 = 3'h2,
    PBEM_PRBS23 = 3'h3,
    PBEM_PRBS31 = 3'h4
  } pbem_pattern_t;

  typedef enum logic [1:0] {
    EYE_IDLE   = 2'h0,
    EYE_SETTLE = 2'h1,
    EYE_MEAS   = 2'h3,
    EYE_STORE  = 2'h2
  } pbem_eye_state_t;

  function automatic logic [5:0] pbem_popcount(input logic [31:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < `PBEM_WORD_W; i++) begin
      c = c + {5'h00, v[i]};
    end
    return c;
  endfunction : pbem_popcount

  // Bit 0 is the oldest bit of a word. With check set, the taps read the received
  // word itself, which makes the checker self-synchronising after one word.
  function automatic logic [31:0] pbem_prbs_step(input logic [2:0]  pat,
                                                 input logic [31:0] prev,
                                                 input logic [31:0] cur,
                                                 input logic        check);
    int          n;
    int          k;
    logic [63:0] h;
    logic [31:0] w;
    w = 32'h00000000;
    unique case (pat)
      PBEM_PRBS9:  begin n = `PBEM_TAP9_N;  k = `PBEM_TAP9_K;  end
      PBEM_PRBS15: begin n = `PBEM_TAP15_N; k = `PBEM_TAP15_K; end
      PBEM_PRBS23: begin n = `PBEM_TAP23_N; k = `PBEM_TAP23_K; end
      PBEM_PRBS31: begin n = `PBEM_TAP31_N; k = `PBEM_TAP31_K; end
      default:     begin n = `PBEM_TAP7_N;  k = `PBEM_TAP7_K;  end
    endcase
    h = {cur, prev};
    for (int i = 0; i < `PBEM_WORD_W; i++) begin
      w[i] = h[32 + i - n] ^ h[32 + i - k];
      if (!check) begin
        h[32 + i] = w[i];
      end
    end
    return w;
  endfunction : pbem_prbs_step
endpackage : pbem_pkg

// *** pbem_prbs.sv ***
// Pattern generator and self-synchronising checker of one lane.
`timescale 1ns/1ps
`include "pbem_cfg.svh"
module pbem_prbs
  import pbem_pkg::*;
(
  // Clock and reset.
  input  wire logic    mclk_i,
  input  wire logic    rst_i,
  // Controller side.
  pbem_prbs_if.engine  prbs
);
  logic [31:0] tx_word_r;
  logic [31:0] tx_word_nxt;
  logic [31:0] rx_prev_r;
  logic [31:0] rx_prev_nxt;
  logic        prev_valid_r;
  logic        prev_valid_nxt;
  logic [5:0]  err_num_r;
  logic [5:0]  err_num_nxt;
  logic        cmp_valid_r;
  logic        cmp_valid_nxt;

  always_comb begin
    tx_word_nxt    = `PBEM_PRBS_SEED;
    rx_prev_nxt    = 32'h00000000;
    prev_valid_nxt = 1'b0;
    err_num_nxt    = 6'h00;
    cmp_valid_nxt  = 1'b0;
    if (prbs.run) begin
      tx_word_nxt    = pbem_prbs_step(prbs.pattern, tx_word_r, 32'h00000000, 1'b0);
      rx_prev_nxt    = prbs.rx_word;
      prev_valid_nxt = 1'b1;
      if (prev_valid_r) begin
        err_num_nxt   = pbem_popcount(prbs.rx_word ^ pbem_prbs_step(prbs.pattern, rx_prev_r,
                                                                    prbs.rx_word, 1'b1));
        cmp_valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_word_r    <= `PBEM_PRBS_SEED;
      rx_prev_r    <= 32'h00000000;
      prev_valid_r <= 1'b0;
      err_num_r    <= 6'h00;
      cmp_valid_r  <= 1'b0;
    end else begin
      tx_word_r    <= tx_word_nxt;
      rx_prev_r    <= rx_prev_nxt;
      prev_valid_r <= prev_valid_nxt;
      err_num_r    <= err_num_nxt;
      cmp_valid_r  <= cmp_valid_nxt;
    end
  end

  assign prbs.tx_word   = tx_word_r;
  assign prbs.err_num   = err_num_r;
  assign prbs.cmp_valid = cmp_valid_r;
endmodule : pbem_prbs

// *** pbem_prbs_if.sv ***
// Signals between the lane controller and its pattern engine.
`timescale 1ns/1ps
interface pbem_prbs_if;
  logic        run;
  logic [2:0]  pattern;
  logic [31:0] rx_word;
  logic [31:0] tx_word;
  logic [5:0]  err_num;
  logic        cmp_valid;
  modport ctrl   (output run, pattern, rx_word, input tx_word, err_num, cmp_valid);
  modport engine (input run, pattern, rx_word, output tx_word, err_num, cmp_valid);
endinterface : pbem_prbs_if

// *** pbem_tb.sv ***
// Self-checking bench of the lane self-test block.
`timescale 1ns/1ps
module tb;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  locks  = 3'h0;
  logic [7:0]  level  = 8'h00;
  logic [31:0] flip   = 32'h0;
  logic        hrdy, hresp, txen, rxen, loop, eyen;
  logic [31:0] hrdata, txd, rxd, ecen, eoff, rd, w0;
  logic [4:0]  phase;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          tn[5] = '{7, 9, 15, 23, 31};
  int          tk[5] = '{6, 5, 14, 18, 28};
  always #25 mclk_i = ~mclk_i;
  pbem_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .tx_data_o(txd), .tx_enable_o(txen), .rx_enable_o(rxen),
    .near_equalizer_loopback_o(loop), .rx_data_i(rxd), .transmit_pll_lock_i(locks[0]),
    .receive_pll_lock_i(locks[1]), .lock_to_data_i(locks[2]), .eye_enable_o(eyen),
    .eye_phase_o(phase), .eye_center_i(ecen), .eye_offset_i(eoff), .eye_level_i(level));
  pbem_lane_model model_u (.mclk_i(mclk_i), .tx_data_i(txd), .loop_i(loop),
    .eye_phase_i(phase), .flip_i(flip), .rx_data_o(rxd), .eye_center_o(ecen),
    .eye_offset_o(eoff));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Hready is waited on at both phases, so a slower slave would still be met.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic [31:0] nxt_word(input int n, input int k, input logic [31:0] w);
    logic [63:0] s;
    s = {32'h0, w};
    for (int i = 32; i < 64; i++) s[i] = s[i - n] ^ s[i - k];
    return s[63:32];
  endfunction : nxt_word
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, 32'h10, 32'h0); chk(rd, 32'h0);
    bus(1'b0, 32'h14, 32'h0); chk(rd, 32'h100);
    bus(1'b0, 32'h1c, 32'h0); chk(rd, 32'h7f80);
    bus(1'b1, 32'h40, 32'hffffffff); bus(1'b0, 32'h40, 32'h0); chk(rd, 32'h0);
    chk(txd, 32'hffffffff);
    chk({29'h0, txen, rxen, loop}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_prbs();
    for (int p = 0; p < 5; p++) begin
      bus(1'b1, 32'h0, {27'h0, p[2:0], 2'h3});
      repeat (8) @(posedge mclk_i);
      chk({29'h0, txen, rxen, loop}, 32'h7);
      @(negedge mclk_i) w0 = txd;
      @(negedge mclk_i) chk(txd, nxt_word(tn[p], tk[p], w0));
      bus(1'b1, 32'h0, {22'h0, 1'b1, 4'h0, p[2:0], 2'h3});
      repeat (40) @(posedge mclk_i);
      bus(1'b0, 32'h8, 32'h0); chk(rd, 32'h0);
      bus(1'b0, 32'hc, 32'h0); chk({31'h0, rd != 32'h0 && rd[4:0] == 5'h0}, 32'h1);
      bus(1'b1, 32'h0, 32'h0);
      repeat (4) @(negedge mclk_i);
      chk({29'h0, txen, rxen, loop}, 32'h0);
    end
    $display("test prbs done");
  endtask : t_prbs
  task automatic t_errors();
    bus(1'b1, 32'h0, 32'h13);
    repeat (8) @(posedge mclk_i);
    bus(1'b1, 32'h0, 32'h213);
    flip <= 32'h1;
    @(posedge mclk_i) flip <= 32'h0;
    repeat (8) @(posedge mclk_i);
    bus(1'b0, 32'h8, 32'h0); chk(rd, 32'h3);
    bus(1'b0, 32'hc, 32'h0); w0 = rd;
    bus(1'b0, 32'hc, 32'h0); chk({31'h0, rd > w0}, 32'h1);
    bus(1'b1, 32'h0, 32'h213); bus(1'b0, 32'h8, 32'h0); chk(rd, 32'h0);
    chk({31'h0, txen}, 32'h1);
    for (int v = 2; v < 8; v += 3) begin
      locks <= v[2:0];
      repeat (8) @(posedge mclk_i);
      bus(1'b0, 32'h4, 32'h0); chk({28'h0, rd[3:0]}, {28'h0, 1'b1, v[2:0]});
    end
    bus(1'b1, 32'h0, 32'h0);
    $display("test errors done");
  endtask : t_errors
  task automatic t_eye();
    logic [7:0] lv[3] = '{8'h40, 8'hc0, 8'h05};
    logic [7:0] ex[3] = '{8'h10, 8'hf0, 8'h05};
    int         g = 0;
    int         c = 0;
    bus(1'b1, 32'h18, 32'h13);
    @(negedge mclk_i);
    @(negedge mclk_i) chk({27'h0, phase}, 32'h13);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 32'h10, 32'hc35 + j);
      bus(1'b1, 32'h0, 32'h100 | (j << 1));
      repeat (2) @(negedge mclk_i);
      chk({31'h0, eyen}, 32'h0);
    end
    bus(1'b1, 32'h0, 32'h0); bus(1'b1, 32'h14, 32'h1); bus(1'b1, 32'h0, 32'h100);
    while (g < 400) begin
      @(negedge mclk_i) g++;
      if (eyen === 1'b1) c++;
      else if (c > 0) break;
    end
    chk(c, 32 * 6);
    bus(1'b0, 32'h4, 32'h0); chk({31'h0, rd[5]}, 32'h1);
    for (int i = 0; i < 32; i++) begin
      bus(1'b0, 32'h80 + 4 * i, 32'h0); chk({16'h0, rd[15:0]}, i);
    end
    bus(1'b1, 32'h1c, 32'h10f0);
    for (int i = 0; i < 3; i++) begin
      level <= lv[i];
      repeat (2) @(posedge mclk_i);
      bus(1'b0, 32'h20, 32'h0); chk({24'h0, rd[7:0]}, {24'h0, ex[i]});
    end
    $display("test eye done");
  endtask : t_eye
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prbs();
    t_errors();
    t_eye();
    report_and_stop();
  end
  // The whole sequence needs under a thousand cycles; twenty thousand means a hang.
  initial begin
    #(50 * 20000);
    num_errors++;
    report_and_stop();
  end
endmodule : tb

// *** pbem_top.sv ***
// Lane self-test block: pattern test, error and bit counters, locks, eye scan.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pbem_cfg.svh"
module pbem_top
  import pbem_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Lane parallel data and path control.
  output logic [31:0]      tx_data_o,
  output logic             tx_enable_o,
  output logic             rx_enable_o,
  output logic             near_equalizer_loopback_o,
  input  wire logic [31:0] rx_data_i,
  // Lock indications from the analog side.
  input  wire logic        transmit_pll_lock_i,
  input  wire logic        receive_pll_lock_i,
  input  wire logic        lock_to_data_i,
  // Eye monitor samplers after the equalizers.
  output logic             eye_enable_o,
  output logic [4:0]       eye_phase_o,
  input  wire logic [31:0] eye_center_i,
  input  wire logic [31:0] eye_offset_i,
  input  wire logic [7:0]  eye_level_i
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic [11:0]     addr_r;
  logic [11:0]     addr_nxt;
  logic            wr_pend_r;
  logic            wr_pend_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic            run_r;
  logic            run_nxt;
  logic            loop_r;
  logic            loop_nxt;
  logic [2:0]      pat_r;
  logic [2:0]      pat_nxt;
  logic [15:0]     rate_r;
  logic [15:0]     rate_nxt;
  logic [15:0]     dwell_r;
  logic [15:0]     dwell_nxt;
  logic [4:0]      man_phase_r;
  logic [4:0]      man_phase_nxt;
  logic [15:0]     bounds_r;
  logic [15:0]     bounds_nxt;
  logic            eye_go;
  logic            cnt_clr;
  logic [31:0]     err_cnt_r;
  logic [31:0]     err_cnt_nxt;
  logic [31:0]     bit_cnt_r;
  logic [31:0]     bit_cnt_nxt;
  logic [2:0]      lock_r;
  logic [2:0]      lock_nxt;
  logic [2:0]      lock_raw;
  logic [2:0]      sync_r [3];
  pbem_eye_state_t eye_st_r;
  pbem_eye_state_t eye_st_nxt;
  logic [4:0]      eye_idx_r;
  logic [4:0]      eye_idx_nxt;
  logic [15:0]     eye_cnt_r;
  logic [15:0]     eye_cnt_nxt;
  logic [15:0]     eye_acc_r;
  logic [15:0]     eye_acc_nxt;
  logic            eye_done_r;
  logic            eye_done_nxt;
  logic [4:0]      phase_r;
  logic [4:0]      phase_nxt;
  logic            eye_en_r;
  logic            eye_en_nxt;
  logic [15:0]     eye_err_r [`PBEM_EYE_STEPS];
  logic            eye_wr;
  logic            eye_avail;
  logic [16:0]     acc_sum;
  logic [32:0]     err_sum;
  logic [32:0]     bit_sum;
  logic [7:0]      lvl_clip;
  logic [7:0]      lvl_r;
  logic [7:0]      lvl_max_r;
  logic [7:0]      lvl_max_nxt;
  logic [7:0]      lvl_min_r;
  logic [7:0]      lvl_min_nxt;
  logic            acc_phase;
  logic [11:0]     ra;

  pbem_prbs_if prbs_if ();

  pbem_prbs u_prbs (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .prbs   (prbs_if.engine)
  );

  assign prbs_if.run     = run_r;
  assign prbs_if.pattern = pat_r;
  assign prbs_if.rx_word = rx_data_i;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Lock pins cross from the analog domain; a change counts once two later stages agree.
  assign lock_raw = {lock_to_data_i, receive_pll_lock_i, transmit_pll_lock_i};

  for (genvar g = 0; g < 3; g++) begin : g_lock
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        sync_r[g] <= 3'h0;
      end else begin
        sync_r[g] <= {sync_r[g][1:0], lock_raw[g]};
      end
    end
    assign lock_nxt[g] = (sync_r[g][1] == sync_r[g][2]) ? sync_r[g][2] : lock_r[g];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Zero-wait slave: read data is fetched in the address phase, so a read right behind
  // a write to the same register returns the value from before that write.
  assign acc_phase = hsel_i & htrans_i[1] & hready_i;
  assign ra        = haddr_i[11:0];
  assign eye_go    = wr_pend_r & (addr_r == `PBEM_OFF_CTRL) & hwdata_i[`PBEM_CTRL_EYE_GO];
  assign cnt_clr   = wr_pend_r & (addr_r == `PBEM_OFF_CTRL) & hwdata_i[`PBEM_CTRL_CLR];

  always_comb begin
    addr_nxt      = acc_phase ? {ra[11:2], 2'b00} : addr_r;
    wr_pend_nxt   = acc_phase & hwrite_i;
    rdata_nxt     = rdata_r;
    run_nxt       = run_r;
    loop_nxt      = loop_r;
    pat_nxt       = pat_r;
    rate_nxt      = rate_r;
    dwell_nxt     = dwell_r;
    man_phase_nxt = man_phase_r;
    bounds_nxt    = bounds_r;
    if (wr_pend_r) begin
      unique case (addr_r)
        `PBEM_OFF_CTRL: begin
          run_nxt  = hwdata_i[`PBEM_CTRL_RUN];
          loop_nxt = hwdata_i[`PBEM_CTRL_LOOP];
          pat_nxt  = hwdata_i[`PBEM_CTRL_PAT_HI:`PBEM_CTRL_PAT_LO];
        end
        `PBEM_OFF_RATE:   rate_nxt      = hwdata_i[15:0];
        `PBEM_OFF_DWELL:  dwell_nxt     = hwdata_i[15:0];
        `PBEM_OFF_PHASE:  man_phase_nxt = hwdata_i[4:0];
        `PBEM_OFF_BOUNDS: bounds_nxt    = hwdata_i[15:0];
        default: begin
        end
      endcase
    end
    if (acc_phase & ~hwrite_i) begin
      rdata_nxt = 32'h00000000;
      if ((ra & `PBEM_EYE_MASK) == `PBEM_OFF_EYE_BASE) begin
        rdata_nxt = {16'h0000, eye_err_r[ra[6:2]]};
      end else begin
        unique case ({ra[11:2], 2'b00})
          `PBEM_OFF_CTRL:    rdata_nxt = {27'h0, pat_r, loop_r, run_r};
          `PBEM_OFF_STATUS:  rdata_nxt = {25'h0, eye_avail, eye_done_r,
                                          (eye_st_r != EYE_IDLE), run_r, lock_r};
          `PBEM_OFF_ERR_CNT: rdata_nxt = err_cnt_r;
          `PBEM_OFF_BIT_CNT: rdata_nxt = bit_cnt_r;
          `PBEM_OFF_RATE:    rdata_nxt = {16'h0000, rate_r};
          `PBEM_OFF_DWELL:   rdata_nxt = {16'h0000, dwell_r};
          `PBEM_OFF_PHASE:   rdata_nxt = {27'h0, man_phase_r};
          `PBEM_OFF_BOUNDS:  rdata_nxt = {16'h0000, bounds_r};
          `PBEM_OFF_LEVEL:   rdata_nxt = {8'h00, lvl_min_r, lvl_max_r, lvl_r};
          default:           rdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_r      <= 12'h000;
      wr_pend_r   <= 1'b0;
      rdata_r     <= 32'h00000000;
      run_r       <= 1'b0;
      loop_r      <= 1'b0;
      pat_r       <= 3'h0;
      rate_r      <= `PBEM_RATE_RST;
      dwell_r     <= `PBEM_DWELL_RST;
      man_phase_r <= 5'h00;
      bounds_r    <= `PBEM_BOUNDS_RST;
      lock_r      <= 3'h0;
    end else begin
      addr_r      <= addr_nxt;
      wr_pend_r   <= wr_pend_nxt;
      rdata_r     <= rdata_nxt;
      run_r       <= run_nxt;
      loop_r      <= loop_nxt;
      pat_r       <= pat_nxt;
      rate_r      <= rate_nxt;
      dwell_r     <= dwell_nxt;
      man_phase_r <= man_phase_nxt;
      bounds_r    <= bounds_nxt;
      lock_r      <= lock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Counters saturate; a clear in the same cycle as new errors keeps the new errors.
  assign err_sum = {1'b0, err_cnt_r} + {27'h0, prbs_if.err_num};
  assign bit_sum = {1'b0, bit_cnt_r} + 33'h000000020;

  always_comb begin
    err_cnt_nxt = err_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    if (cnt_clr) begin
      err_cnt_nxt = 32'h00000000;
      bit_cnt_nxt = 32'h00000000;
    end
    if (prbs_if.cmp_valid) begin
      if (cnt_clr) begin
        err_cnt_nxt = {26'h0, prbs_if.err_num};
        bit_cnt_nxt = 32'h00000020;
      end else begin
        err_cnt_nxt = err_sum[32] ? 32'hffffffff : err_sum[31:0];
        bit_cnt_nxt = bit_sum[32] ? 32'hffffffff : bit_sum[31:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      err_cnt_r <= 32'h00000000;
      bit_cnt_r <= 32'h00000000;
    end else begin
      err_cnt_r <= err_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // The eye scan refuses to start on a slow lane or with the loopback closed.
  assign eye_avail = (rate_r > `PBEM_EYE_MIN_MBPS);
  assign acc_sum   = {1'b0, eye_acc_r} + {11'h0, pbem_popcount(eye_center_i ^ eye_offset_i)};
  assign eye_wr    = (eye_st_r == EYE_STORE);

  always_comb begin
    eye_st_nxt   = eye_st_r;
    eye_idx_nxt  = eye_idx_r;
    eye_cnt_nxt  = eye_cnt_r;
    eye_acc_nxt  = eye_acc_r;
    eye_done_nxt = eye_done_r;
    unique case (eye_st_r)
      EYE_IDLE: begin
        if (eye_go & eye_avail & ~loop_nxt) begin
          eye_st_nxt   = EYE_SETTLE;
          eye_idx_nxt  = 5'h00;
          eye_cnt_nxt  = 16'h0000;
          eye_done_nxt = 1'b0;
        end
      end
      EYE_SETTLE: begin
        eye_cnt_nxt = eye_cnt_r + 16'h0001;
        if (eye_cnt_r[3:0] == `PBEM_SETTLE_CYC - 4'h1) begin
          eye_st_nxt  = EYE_MEAS;
          eye_cnt_nxt = 16'h0000;
          eye_acc_nxt = 16'h0000;
        end
      end
      EYE_MEAS: begin
        eye_acc_nxt = acc_sum[16] ? 16'hffff : acc_sum[15:0];
        eye_cnt_nxt = eye_cnt_r + 16'h0001;
        if ((eye_cnt_r + 16'h0001) >= dwell_r) begin
          eye_st_nxt = EYE_STORE;
        end
      end
      EYE_STORE: begin
        eye_cnt_nxt = 16'h0000;
        if (eye_idx_r == `PBEM_EYE_LAST) begin
          eye_st_nxt   = EYE_IDLE;
          eye_done_nxt = 1'b1;
        end else begin
          eye_st_nxt  = EYE_SETTLE;
          eye_idx_nxt = eye_idx_r + 5'h01;
        end
      end
    endcase
    eye_en_nxt = (eye_st_nxt != EYE_IDLE);
    phase_nxt  = (eye_st_nxt != EYE_IDLE) ? eye_idx_nxt : man_phase_r;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eye_st_r   <= EYE_IDLE;
      eye_idx_r  <= 5'h00;
      eye_cnt_r  <= 16'h0000;
      eye_acc_r  <= 16'h0000;
      eye_done_r <= 1'b0;
      eye_en_r   <= 1'b0;
      phase_r    <= 5'h00;
    end else begin
      eye_st_r   <= eye_st_nxt;
      eye_idx_r  <= eye_idx_nxt;
      eye_cnt_r  <= eye_cnt_nxt;
      eye_acc_r  <= eye_acc_nxt;
      eye_done_r <= eye_done_nxt;
      eye_en_r   <= eye_en_nxt;
      phase_r    <= phase_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `PBEM_EYE_STEPS; i++) begin
        eye_err_r[i] <= 16'h0000;
      end
    end else if (eye_wr) begin
      eye_err_r[eye_idx_r] <= eye_acc_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Amplitude is clipped to the capture window before it is tracked.
  always_comb begin
    lvl_clip = eye_level_i;
    if ($signed(eye_level_i) > $signed(bounds_r[15:8])) begin
      lvl_clip = bounds_r[15:8];
    end else if ($signed(eye_level_i) < $signed(bounds_r[7:0])) begin
      lvl_clip = bounds_r[7:0];
    end
    lvl_max_nxt = lvl_max_r;
    lvl_min_nxt = lvl_min_r;
    if (eye_go & (eye_st_r == EYE_IDLE)) begin
      lvl_max_nxt = bounds_r[7:0];
      lvl_min_nxt = bounds_r[15:8];
    end else if (eye_st_r == EYE_MEAS) begin
      lvl_max_nxt = ($signed(lvl_clip) > $signed(lvl_max_r)) ? lvl_clip : lvl_max_r;
      lvl_min_nxt = ($signed(lvl_clip) < $signed(lvl_min_r)) ? lvl_clip : lvl_min_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lvl_r     <= 8'h00;
      lvl_max_r <= 8'h80;
      lvl_min_r <= 8'h7f;
    end else begin
      lvl_r     <= lvl_clip;
      lvl_max_r <= lvl_max_nxt;
      lvl_min_r <= lvl_min_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  assign hreadyout_o               = 1'b1;
  assign hresp_o                   = 1'b0;
  assign hrdata_o                  = rdata_r;
  assign tx_data_o                 = prbs_if.tx_word;
  assign tx_enable_o               = run_r;
  assign rx_enable_o               = run_r;
  assign near_equalizer_loopback_o = loop_r;
  assign eye_enable_o              = eye_en_r;
  assign eye_phase_o               = phase_r;
endmodule : pbem_top

// *** pbem_top_asserts.sv ***
// Concurrent checks on the ports of the lane self-test block.
`timescale 1ns/1ps
module pbem_top_asserts (
  // Clock and reset.
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // Watched outputs.
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [31:0] tx_data_o,
  input wire logic        tx_enable_o,
  input wire logic        rx_enable_o,
  input wire logic        near_equalizer_loopback_o,
  input wire logic        eye_enable_o,
  input wire logic [4:0]  eye_phase_o
);
  // The bench programs a dwell of one, so a phase lasts four settle, one measure, one store.
  localparam int STEP_CYC = 6;
  logic [4:0] phase_q_r;
  logic [7:0] run_len_r;
  logic [7:0] run_len_nxt;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    run_len_nxt = 8'h01;
    if (eye_enable_o && eye_phase_o == phase_q_r) begin
      run_len_nxt = run_len_r + 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    phase_q_r <= eye_phase_o;
    run_len_r <= run_len_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("Bus answer not ready or not okay.");
  txrx_pair_a: assert property (tx_enable_o == rx_enable_o)
    else $error("Transmit and receive enables differ.");
  gen_start_a: assert property ($rose(tx_enable_o) |-> ##[1:2] tx_data_o != 32'hffffffff)
    else $error("Generator did not start.");
  stop_idle_a: assert property ((!tx_enable_o) [*3] |-> tx_data_o == 32'hffffffff)
    else $error("Stopped lane still sends pattern.");
  gen_step_a: assert property (tx_enable_o && $past(tx_enable_o) && $past(tx_enable_o, 2)
    |-> tx_data_o != $past(tx_data_o))
    else $error("Pattern word repeated.");
  phase_walk_a: assert property (eye_enable_o && $past(eye_enable_o)
    && eye_phase_o != $past(eye_phase_o) |-> eye_phase_o == $past(eye_phase_o) + 5'h01)
    else $error("Eye phase skipped a step.");
  step_len_a: assert property (eye_enable_o && $past(eye_enable_o)
    && eye_phase_o != $past(eye_phase_o) && $past(eye_phase_o) != 5'h00
    |-> run_len_r == STEP_CYC)
    else $error("Eye phase step has wrong length.");
  eye_noloop_a: assert property ($rose(eye_enable_o) |-> !near_equalizer_loopback_o)
    else $error("Eye scan started with loopback closed.");
endmodule : pbem_top_asserts

bind pbem_top pbem_top_asserts chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .tx_data_o(tx_data_o),
  .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
  .near_equalizer_loopback_o(near_equalizer_loopback_o),
  .eye_enable_o(eye_enable_o), .eye_phase_o(eye_phase_o));
